// ### common/interval_timer_pkg.sv
package interval_timer_pkg;

    // Register word indices; the bus byte address is the index times four
    localparam logic [7:0] IDX_MODE_CONTROL = 8'hD8;
    localparam logic [7:0] IDX_COUNT_VALUE = 8'hD9;
    localparam logic [7:0] IDX_IRQ_STATUS = 8'hDA;
    localparam logic [7:0] IDX_IRQ_MASK = 8'hDB;
    localparam logic [7:0] IDX_SYS_CONTROL = 8'hDC;
    localparam int ADDR_W = 10;

    // Mode register field positions
    localparam int MODE_ENABLE_BIT = 7;
    localparam int MODE_RATE_LSB = 4;
    localparam int MODE_RTC_BIT = 0;
    localparam logic [7:0] MODE_WRITE_MASK = 8'hF1;

    // Status/mask field positions
    localparam int IRQ_OVF_BIT = 0;
    localparam int IRQ_WAKE_BIT = 1;
    localparam logic [1:0] IRQ_BITS_MASK = 2'h3;

    // System control bits
    localparam int SYS_GREEN_BIT = 0;

    // Reset values
    localparam logic [7:0] MODE_RESET = 8'h00;
    localparam logic [7:0] COUNT_RESET = 8'h00;

    // Counter limits
    localparam logic [7:0] COUNT_FULL = 8'hFF;
    localparam logic [7:0] COUNT_ZERO = 8'h00;

    // Timing
    localparam int RTC_DIVIDE = 64;
    localparam int RATE_MAX_DIV = 256;
    localparam logic [7:0] IRQ_VECTOR = 8'h08;

    // Operating modes of the surrounding system
    typedef enum logic [1:0] {
        OP_NORMAL = 2'b00,
        OP_SLOW = 2'b01,
        OP_GREEN = 2'b11
    } op_mode_t;

    // Decoded mode register
    typedef struct packed {
        logic enable;
        logic [2:0] rate;
        logic rtc_sel;
    } mode_fields_t;

    // Avalon request bundle
    typedef struct packed {
        logic [ADDR_W-1:0] address;
        logic read;
        logic write;
        logic [31:0] writedata;
        logic [3:0] byteenable;
    } avalon_req_t;

endpackage

// ### hdl/timer_prescaler.sv
`timescale 1ns/1ps

// Free running divider producing one-cycle ticks at clk/(2^(8-rate))
module timer_prescaler #(
    parameter int DIV_W = 8
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic run,
    input wire logic [2:0] rate,
    output logic tick
);
    logic [DIV_W-1:0] div_ff;
    logic [DIV_W-1:0] nxt_div;
    logic [DIV_W-1:0] top;

    // Terminal count for the selected ratio; 000 gives the longest period
    always_comb begin
        top = DIV_W'((1 << (DIV_W - int'(rate))) - 1);
        nxt_div = (div_ff >= top) ? '0 : div_ff + 1'b1;
    end

    // Divider holds while the timer is stopped, so a restart resumes the old phase
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            div_ff <= '0;
        end else if (run) begin
            div_ff <= nxt_div;
        end
    end

    assign tick = run && (div_ff >= top);
endmodule // timer_prescaler

// ### hdl/rtc_divider.sv
`timescale 1ns/1ps

// Samples the 32 kHz crystal level and ticks once per RTC_DIVIDE rising edges
module rtc_divider #(
    parameter int DIVIDE = interval_timer_pkg::RTC_DIVIDE
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic run,
    input wire logic xtal_in,
    output logic tick
);
    logic sync1_ff;
    logic sync2_ff;
    logic last_ff;
    logic [$clog2(DIVIDE)-1:0] cnt_ff;
    logic edge_seen;

    // Two stage synchroniser; crystal is asynchronous to clk
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            sync1_ff <= 1'b0;
            sync2_ff <= 1'b0;
            last_ff <= 1'b0;
        end else begin
            sync1_ff <= xtal_in;
            sync2_ff <= sync1_ff;
            last_ff <= sync2_ff;
        end
    end

    assign edge_seen = sync2_ff && !last_ff;

    // Edge counter, frozen while disabled
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            cnt_ff <= '0;
        end else if (run && edge_seen) begin
            cnt_ff <= cnt_ff + 1'b1;
        end
    end

    assign tick = run && edge_seen && (cnt_ff == '1);
endmodule // rtc_divider

// ### hdl/interval_timer.sv
// Implementation choice: register access over Avalon-MM.
`timescale 1ns/1ps

module interval_timer #(
    parameter bit RTC_OPTION = 1'b1
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [interval_timer_pkg::ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic xtal_32k,
    input wire logic [1:0] op_mode_in,
    output logic wake_req,
    output logic [7:0] irq_vector,
    output logic irq
);
    // Timer registers
    logic [7:0] mode_ff;          // Mode/control register
    logic [7:0] count_ff;         // Live count
    logic [1:0] status_ff;        // Sticky events
    logic [1:0] mask_ff;          // Interrupt enables
    logic [1:0] resume_mode_ff;   // Mode to return to after green wake
    logic wake_ff;                // Wake request output
    logic irq_ff;                 // Interrupt output
    logic [31:0] rdata_ff;        // Read data
    logic ack_ff;                 // Access acknowledged one cycle after request
    interval_timer_pkg::mode_fields_t mode;
    interval_timer_pkg::avalon_req_t req;
    logic pre_tick;
    logic rtc_tick;
    logic tick;
    logic rtc_active;
    logic overflow;
    logic wr_hit;
    logic rd_hit;
    logic be0;
    logic [1:0] nxt_status;
    logic wait_ff;                // Registered waitrequest, high while idle
    logic [7:0] vector_ff;        // Registered interrupt vector

    // Bundle bus request
    assign req = '{avs_address, avs_read, avs_write, avs_writedata, avs_byteenable};

    // Decode word index from a byte address
    function automatic logic sel(input logic [interval_timer_pkg::ADDR_W-1:0] a,
                                 input logic [7:0] idx);
        sel = (a == {idx, 2'b00});
    endfunction

    assign mode = '{mode_ff[interval_timer_pkg::MODE_ENABLE_BIT],
                    mode_ff[interval_timer_pkg::MODE_RATE_LSB +: 3],
                    mode_ff[interval_timer_pkg::MODE_RTC_BIT]};

    // Bit 0 only acts when the RTC build option is present
    assign rtc_active = mode.rtc_sel && RTC_OPTION;

    // Tick sources; rate ignored in RTC mode
    timer_prescaler #(.DIV_W(8)) u_pre (
        .clk(clk),
        .sys_rst(sys_rst),
        .run(mode.enable && !rtc_active),
        .rate(mode.rate),
        .tick(pre_tick)
    );

    rtc_divider #(.DIVIDE(interval_timer_pkg::RTC_DIVIDE)) u_rtc (
        .clk(clk),
        .sys_rst(sys_rst),
        .run(mode.enable && rtc_active),
        .xtal_in(xtal_32k),
        .tick(rtc_tick)
    );

    // Operating mode does not gate ticks: the timer runs in all modes.
    // The prescaler keeps its phase across a stop, so the first count
    // after a restart may come early by up to one prescaled period;
    // reloading the count leaves that phase as it is; only sys_rst clears it.
    assign tick = mode.enable && (rtc_active ? rtc_tick : pre_tick);

    // Overflow is the tick that carries the count from full scale to zero
    assign overflow = tick && (count_ff == interval_timer_pkg::COUNT_FULL);

    // Byte lane 0 carries every register; other lanes are ignored
    assign be0 = req.byteenable[0];
    // A write lands only at the edge where waitrequest is seen low, so the
    // master and the register agree on the cycle in which it took effect
    assign wr_hit = req.write && ack_ff && be0;
    // A read is captured in the wait cycle so its data stands at the
    // completing edge; the count it returns is one cycle old
    assign rd_hit = req.read && !ack_ff;

    // Mode register; reserved bits never stored
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            mode_ff <= interval_timer_pkg::MODE_RESET;
        end else if (wr_hit && sel(req.address, interval_timer_pkg::IDX_MODE_CONTROL)) begin
            mode_ff <= req.writedata[7:0] & interval_timer_pkg::MODE_WRITE_MASK;
        end
    end

    // Counter: a write wins over a tick; wrap keeps going from zero
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            count_ff <= interval_timer_pkg::COUNT_RESET;
        end else if (wr_hit && sel(req.address, interval_timer_pkg::IDX_COUNT_VALUE)) begin
            count_ff <= req.writedata[7:0];
        end else if (tick) begin
            count_ff <= count_ff + 8'h01;
        end
    end

    // Sticky status: write one to clear, new event wins over clear
    always_comb begin
        nxt_status = status_ff;
        if (wr_hit && sel(req.address, interval_timer_pkg::IDX_IRQ_STATUS)) begin
            nxt_status = status_ff & ~req.writedata[1:0];
        end
        if (overflow) begin
            nxt_status[interval_timer_pkg::IRQ_OVF_BIT] = 1'b1;
        end
        if (overflow && op_mode_in == interval_timer_pkg::OP_GREEN) begin
            nxt_status[interval_timer_pkg::IRQ_WAKE_BIT] = 1'b1;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            status_ff <= 2'h0;
        end else begin
            status_ff <= nxt_status;
        end
    end

    // Mask register
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            mask_ff <= 2'h0;
        end else if (wr_hit && sel(req.address, interval_timer_pkg::IDX_IRQ_MASK)) begin
            mask_ff <= req.writedata[1:0] & interval_timer_pkg::IRQ_BITS_MASK;
        end
    end

    // Interrupt level and fixed vector
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            irq_ff <= 1'b0;
        end else begin
            irq_ff <= |(nxt_status & mask_ff);
        end
    end

    // Remember the mode before green, request return on overflow in green
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            resume_mode_ff <= interval_timer_pkg::OP_NORMAL;
            wake_ff <= 1'b0;
        end else begin
            if (op_mode_in != interval_timer_pkg::OP_GREEN) begin
                resume_mode_ff <= op_mode_in;
            end
            wake_ff <= overflow && (op_mode_in == interval_timer_pkg::OP_GREEN);
        end
    end

    // Bus slave: one wait cycle, then acknowledge
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            ack_ff <= 1'b0;
        end else begin
            ack_ff <= (req.read || req.write) && !ack_ff;
        end
    end

    // Waitrequest from its own flop: high while idle and during the wait
    // cycle, low for exactly the completing cycle of each transfer
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            wait_ff <= 1'b1; // Idle slave holds the master off
        end else begin
            wait_ff <= !((req.read || req.write) && !ack_ff);
        end
    end

    // Vector held in a flop so every output leaves a register
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            vector_ff <= interval_timer_pkg::IRQ_VECTOR;
        end else begin
            vector_ff <= interval_timer_pkg::IRQ_VECTOR;
        end
    end

    // Read mux; unmapped addresses return zero
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            rdata_ff <= 32'h0000_0000;
        end else if (rd_hit) begin
            if (sel(req.address, interval_timer_pkg::IDX_MODE_CONTROL)) begin
                rdata_ff <= {24'h00_0000, mode_ff};
            end else if (sel(req.address, interval_timer_pkg::IDX_COUNT_VALUE)) begin
                rdata_ff <= {24'h00_0000, count_ff};
            end else if (sel(req.address, interval_timer_pkg::IDX_IRQ_STATUS)) begin
                rdata_ff <= {30'h0000_0000, status_ff};
            end else if (sel(req.address, interval_timer_pkg::IDX_IRQ_MASK)) begin
                rdata_ff <= {30'h0000_0000, mask_ff};
            end else if (sel(req.address, interval_timer_pkg::IDX_SYS_CONTROL)) begin
                rdata_ff <= {30'h0000_0000, resume_mode_ff};
            end else begin
                rdata_ff <= 32'h0000_0000;
            end
        end
    end

    assign avs_readdata = rdata_ff;
    assign avs_waitrequest = wait_ff;
    assign irq = irq_ff;
    assign wake_req = wake_ff;
    assign irq_vector = vector_ff;

    // Checks; all run on clk and stay quiet while reset is high.
    // Each watches a flop or output that the logic above drives.

    // Overflow leaves the flag set on the next cycle
    chk_flag_sets: assert property (
        @(posedge clk) disable iff (sys_rst)
        overflow |=> status_ff[interval_timer_pkg::IRQ_OVF_BIT]
    ) else $error("overflow flag not set");

    // Without a write to status the flag never drops on its own
    chk_flag_sticky: assert property (
        @(posedge clk) disable iff (sys_rst)
        status_ff[interval_timer_pkg::IRQ_OVF_BIT]
            && !(req.write && sel(req.address, interval_timer_pkg::IDX_IRQ_STATUS))
        |=> status_ff[interval_timer_pkg::IRQ_OVF_BIT]
    ) else $error("flag lost");

    // Writing a one clears the flag unless a new overflow lands with it
    chk_flag_clear: assert property (
        @(posedge clk) disable iff (sys_rst)
        wr_hit && sel(req.address, interval_timer_pkg::IDX_IRQ_STATUS)
            && req.writedata[interval_timer_pkg::IRQ_OVF_BIT] && !overflow
        |=> !status_ff[interval_timer_pkg::IRQ_OVF_BIT]
    ) else $error("flag not cleared");

    // A stopped timer keeps its count unless software writes it
    chk_stop_holds: assert property (
        @(posedge clk) disable iff (sys_rst)
        !mode.enable && !req.write |=> $stable(count_ff)
    ) else $error("count moved");

    // Each tick adds exactly one
    chk_count_step: assert property (
        @(posedge clk) disable iff (sys_rst)
        tick && !wr_hit |=> count_ff == $past(count_ff) + 8'h01
    ) else $error("step");

    // No reload value: overflow lands on zero unless a count write wins
    chk_wrap_zero: assert property (
        @(posedge clk) disable iff (sys_rst)
        overflow && !wr_hit |=> count_ff == interval_timer_pkg::COUNT_ZERO
    ) else $error("no wrap");

    // A count write replaces the running value at once
    chk_count_write: assert property (
        @(posedge clk) disable iff (sys_rst)
        wr_hit && sel(req.address, interval_timer_pkg::IDX_COUNT_VALUE)
        |=> count_ff == $past(req.writedata[7:0])
    ) else $error("count write lost");

    // Reserved mode bits are never stored, so they read as zero
    chk_reserved_zero: assert property (
        @(posedge clk) disable iff (sys_rst)
        (mode_ff & ~interval_timer_pkg::MODE_WRITE_MASK) == 8'h00
    ) else $error("reserved bit stored");

    // An unmasked overflow raises the interrupt line
    chk_irq_level: assert property (
        @(posedge clk) disable iff (sys_rst)
        overflow && mask_ff[interval_timer_pkg::IRQ_OVF_BIT] |=> irq
    ) else $error("irq missing");

    // The line is exactly the unmasked status, no more and no less
    chk_irq_follows: assert property (
        @(posedge clk) disable iff (sys_rst)
        irq == |(status_ff & $past(mask_ff))
    ) else $error("irq level wrong");

    // Overflow in green mode asks for a wake-up
    chk_wake_green: assert property (
        @(posedge clk) disable iff (sys_rst)
        overflow && op_mode_in == interval_timer_pkg::OP_GREEN |=> wake_req
    ) else $error("no wake");

    // A wake-up has no other cause than a green-mode overflow
    chk_wake_cause: assert property (
        @(posedge clk) disable iff (sys_rst)
        wake_req |-> $past(overflow) && $past(op_mode_in) == interval_timer_pkg::OP_GREEN
    ) else $error("stray wake");

    // In crystal mode the prescaler must stay silent
    chk_rtc_rate_off: assert property (
        @(posedge clk) disable iff (sys_rst)
        rtc_active |-> !pre_tick
    ) else $error("prescaler ticked in rtc mode");

    // Without the build option the crystal path never ticks
    chk_rtc_gate: assert property (
        @(posedge clk) disable iff (sys_rst)
        !RTC_OPTION |-> !rtc_active && !rtc_tick
    ) else $error("rtc without option");

    // At most one cycle with waitrequest low per transfer
    chk_one_wait: assert property (
        @(posedge clk) disable iff (sys_rst)
        (avs_read || avs_write) && !avs_waitrequest |=> avs_waitrequest
    ) else $error("waitrequest held low");

    // Main scenarios reached
    cov_overflow: cover property (@(posedge clk) overflow);
    cov_green_wake: cover property (@(posedge clk) wake_req);
    cov_irq: cover property (@(posedge clk) irq);
    cov_rtc_tick: cover property (@(posedge clk) rtc_tick);
    cov_flag_clear: cover property (@(posedge clk)
        wr_hit && sel(req.address, interval_timer_pkg::IDX_IRQ_STATUS) && status_ff[0]);
endmodule // interval_timer

// ### sim/tb_interval_timer.sv
`timescale 1ns/1ps

// Self-checking bench for the interval timer, driven over its Avalon port
module tb_interval_timer;
    logic clk; // 250 MHz system clock
    logic sys_rst; // Active high asynchronous reset
    logic [interval_timer_pkg::ADDR_W-1:0] avs_address; // Byte address, index times four
    logic avs_read;
    logic avs_write;
    logic [31:0] avs_writedata;
    logic [3:0] avs_byteenable; // Always full word
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic xtal_32k; // Crystal stand-in, still unless a pulse train is sent
    logic [1:0] op_mode_in; // System operating mode
    logic wake_req;
    logic [7:0] irq_vector;
    logic irq;
    int err_count; // Mismatches seen
    int cmp_count; // Comparisons made
    logic [31:0] rd; // Last value read
    logic [7:0] prev; // Count frozen by the last stop
    int div; // Prescaler ratio of the current pass

    interval_timer #(.RTC_OPTION(1'h1)) dut (
        .clk(clk),
        .sys_rst(sys_rst),
        .avs_address(avs_address),
        .avs_read(avs_read),
        .avs_write(avs_write),
        .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest),
        .xtal_32k(xtal_32k),
        .op_mode_in(op_mode_in),
        .wake_req(wake_req),
        .irq_vector(irq_vector),
        .irq(irq)
    );

    // Half of the 4 ns period
    always #2 clk = ~clk;

    // Prints the counts and the verdict, then stops the run
    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // Exact four-state comparison
    task automatic check_eq(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Window comparison: prescaler phase leaves one count of slack
    task automatic check_in(input logic [7:0] got, input logic [7:0] lo, input logic [7:0] hi);
        cmp_count++;
        if ($isunknown(got) || got < lo || got > hi) begin
            err_count++;
            $display("CHECK FAILED at %0t: got %h outside %h..%h", $time, got, lo, hi);
        end
    endtask

    // One transfer, held until waitrequest is sampled low; ends one edge later
    task automatic bus_xfer(input logic wr, input logic [7:0] idx, input logic [7:0] d);
        int n;
        n = 0;
        avs_address <= {idx, 2'h0};
        avs_writedata <= {24'h000000, d};
        avs_write <= wr;
        avs_read <= !wr;
        do begin
            @(posedge clk);
            n++;
        end while (avs_waitrequest !== 1'h0 && n < 64);
        rd = avs_readdata;
        if (avs_waitrequest !== 1'h0) begin
            err_count++;
            $display("CHECK FAILED at %0t: bus never answered", $time);
            finish_test();
        end
        avs_write <= 1'h0;
        avs_read <= 1'h0;
        @(posedge clk);
    endtask

    // Register write
    task automatic reg_write(input logic [7:0] idx, input logic [7:0] d);
        bus_xfer(1'h1, idx, d);
    endtask

    // Register read into rd
    task automatic reg_read(input logic [7:0] idx);
        bus_xfer(1'h0, idx, 8'h00);
    endtask

    // Register read and exact check
    task automatic reg_check(input logic [7:0] idx, input logic [31:0] exp);
        reg_read(idx);
        check_eq(rd, exp);
    endtask

    // Bounded wait for irq, or for the wake pulse when wake is set
    task automatic wait_high(input logic wake, input int lim);
        int n;
        n = 0;
        while ((wake ? wake_req : irq) !== 1'h1) begin
            @(posedge clk);
            n++;
            if (n > lim) begin
                err_count++;
                $display("CHECK FAILED at %0t: event never came", $time);
                finish_test();
            end
        end
    endtask

    // Crystal pulses, one rising edge per 8 system cycles; the line rests low
    task automatic xtal_edges(input int n);
        repeat (n) begin
            xtal_32k <= 1'h1;
            repeat (4) @(posedge clk);
            xtal_32k <= 1'h0;
            repeat (4) @(posedge clk);
        end
    endtask

    // Main sequence
    initial begin
        clk = 1'h0;
        sys_rst = 1'h1;
        avs_address = '0;
        avs_read = 1'h0;
        avs_write = 1'h0;
        avs_writedata = 32'h0;
        avs_byteenable = 4'hF;
        xtal_32k = 1'h0;
        op_mode_in = interval_timer_pkg::OP_NORMAL;
        err_count = 0;
        cmp_count = 0;
        repeat (4) @(posedge clk);
        sys_rst <= 1'h0;
        @(posedge clk);
        // Reset values, reserved bits, an unmapped hole, a stopped counter
        reg_check(8'hD8, 32'h0);
        reg_check(8'hD9, 32'h0);
        reg_check(8'hD0, 32'h0);
        reg_write(8'hD8, 8'h0E);
        reg_check(8'hD8, 32'h0);
        reg_write(8'hD9, 8'hA5);
        repeat (600) @(posedge clk);
        reg_check(8'hD9, 32'hA5);
        reg_write(8'hD9, 8'h00);
        prev = 8'h00;
        // Every prescale code: 16 ticks per run, then frozen, resumed next pass
        for (int r = 0; r < 8; r++) begin
            div = 256 >> r;
            reg_write(8'hD8, {1'h0, r[2:0], 4'h0});
            reg_write(8'hD8, {1'h1, r[2:0], 4'h0});
            repeat (16 * div) @(posedge clk);
            reg_write(8'hD8, {1'h0, r[2:0], 4'h0});
            reg_read(8'hD9);
            check_in(rd[7:0] - prev, 8'h0F, 8'h12);
            prev = rd[7:0];
            repeat (4 * div) @(posedge clk);
            reg_check(8'hD9, {24'h000000, prev});
        end
        // Overflow from a preset near full scale, interrupt unmasked
        reg_write(8'hD9, 8'hFC);
        reg_write(interval_timer_pkg::IDX_IRQ_MASK, 8'h01);
        reg_write(8'hD8, 8'hF0);
        wait_high(1'h0, 40);
        check_eq(irq_vector, 32'h8);
        reg_check(interval_timer_pkg::IDX_IRQ_STATUS, 32'h1);
        reg_read(8'hD9);
        check_in(rd[7:0], 8'h00, 8'h08);
        reg_write(8'hD8, 8'h70);
        repeat (64) @(posedge clk);
        reg_check(interval_timer_pkg::IDX_IRQ_STATUS, 32'h1);
        // Masking drops the line, unmasking raises it, clearing drops it
        reg_write(interval_timer_pkg::IDX_IRQ_MASK, 8'h00);
        @(posedge clk);
        check_eq(irq, 32'h0);
        reg_write(interval_timer_pkg::IDX_IRQ_MASK, 8'h01);
        @(posedge clk);
        check_eq(irq, 32'h1);
        reg_write(interval_timer_pkg::IDX_IRQ_STATUS, 8'h01);
        @(posedge clk);
        check_eq(irq, 32'h0);
        reg_check(interval_timer_pkg::IDX_IRQ_STATUS, 32'h0);
        // Green mode: counting goes on and overflow wakes for one cycle
        op_mode_in <= interval_timer_pkg::OP_GREEN;
        reg_write(8'hD9, 8'hFE);
        reg_write(8'hD8, 8'hF0);
        wait_high(1'h1, 40);
        @(posedge clk);
        check_eq(wake_req, 32'h0);
        reg_check(interval_timer_pkg::IDX_IRQ_STATUS, 32'h3);
        reg_check(interval_timer_pkg::IDX_SYS_CONTROL, 32'h0);
        reg_write(8'hD8, 8'h70);
        reg_write(interval_timer_pkg::IDX_IRQ_STATUS, 8'h03);
        // Crystal source in slow mode; prescale bits left set must not matter
        op_mode_in <= interval_timer_pkg::OP_SLOW;
        reg_write(8'hD9, 8'hFE);
        reg_write(8'hD8, 8'h71);
        reg_check(interval_timer_pkg::IDX_SYS_CONTROL, 32'h1);
        reg_write(8'hD8, 8'hF1);
        xtal_edges(63);
        reg_check(8'hD9, 32'hFE);
        xtal_edges(1);
        reg_check(8'hD9, 32'hFF);
        xtal_edges(64);
        reg_check(8'hD9, 32'h0);
        reg_check(interval_timer_pkg::IDX_IRQ_STATUS, 32'h1);
        finish_test();
    end
endmodule // tb_interval_timer
